// *** src/history_ram.sv ***
// Rolling sample history memory with registered read
`timescale 1ns/1ps
module history_ram
  import trip_value_recorder_pkg::*;
(
  // Clock
  input  wire logic               clk,
  // Write side
  input  wire logic               wr_en,
  input  wire logic [HIST_AW-1:0] wr_addr,
  input  wire triple_t            wr_data,
  // Read side
  input  wire logic [HIST_AW-1:0] rd_addr,
  output triple_t                 rd_data
);

  triple_t mem [HIST_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// *** src/trip_value_recorder.sv ***
// Trip value recorder top: captures pre-fault and fault values, reports on trip
// What this block does
// RQ1: Start rising edge latches pre-fault and fault values, then waits for trip.
// RQ2: A new start edge before trip replaces the latched values.
// RQ3: Trip trigger generates events carrying the latched values.
// RQ4: Events go to event list and supervisory system without further request.
// RQ5: Pre-fault value is the sample taken 100 ms before start edge.
// RQ6: Fault value is mean of samples at 10 ms and 20 ms after start.
// RQ7: Secondary inputs are scaled to primary values before capture.
// RQ8: No binary outputs; only pre-fault and fault events leave the block.
// RQ9: No settable parameters; capture timing is fixed.
// RQ10: Configuration ties the three inputs to one allowed source type.
// RQ11: Two event kinds, pre-fault and fault, carry applied input values.
// RQ12: A rolling history covers at least 100 ms of samples.
`timescale 1ns/1ps
module trip_value_recorder
  import trip_value_recorder_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rstn,
  // Measurement stream
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] sec_ch0,
  input  wire logic [SAMPLE_W-1:0] sec_ch1,
  input  wire logic [SAMPLE_W-1:0] sec_ch2,
  input  wire logic [SCALE_W-1:0]  ratio_ch0,
  input  wire logic [SCALE_W-1:0]  ratio_ch1,
  input  wire logic [SCALE_W-1:0]  ratio_ch2,
  // Protection inputs
  input  wire logic                start_request_input,
  input  wire logic                trip_trigger_input,
  // Event list output
  output logic                     list_valid,
  output trip_event_t              list_event,
  // Supervisory output
  output logic                     scada_valid,
  output trip_event_t              scada_event
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic       start_s1;
  logic       start_s2;
  logic       start_s3;
  logic       trip_s1;
  logic       trip_s2;
  logic       trip_s3;
  logic       next_start_s1;
  logic       next_trip_s1;
  logic       start_edge;
  logic       trip_edge;

  always_comb begin
    next_start_s1 = start_request_input;
    next_trip_s1  = trip_trigger_input;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_s1 <= 1'b0;
      start_s2 <= 1'b0;
      start_s3 <= 1'b0;
      trip_s1  <= 1'b0;
      trip_s2  <= 1'b0;
      trip_s3  <= 1'b0;
    end else begin
      start_s1 <= next_start_s1;
      start_s2 <= start_s1;
      start_s3 <= start_s2;
      trip_s1  <= next_trip_s1;
      trip_s2  <= trip_s1;
      trip_s3  <= trip_s2;
    end
  end

  assign start_edge = start_s2 & ~start_s3;
  assign trip_edge  = trip_s2 & ~trip_s3;

  // ------------------------------------------------------------
  // Scaling and history
  // ------------------------------------------------------------
  triple_t            scaled;
  triple_t            rd_data;
  logic [HIST_AW-1:0] wptr;
  logic [HIST_AW-1:0] next_wptr;
  logic [HIST_AW-1:0] rd_addr;

  always_comb begin
    scaled.ch0 = to_primary(sec_ch0, ratio_ch0); // see RQ7
    scaled.ch1 = to_primary(sec_ch1, ratio_ch1); // see RQ7
    scaled.ch2 = to_primary(sec_ch2, ratio_ch2); // see RQ7
    next_wptr  = sample_valid ? wptr + 7'h01 : wptr; // see RQ12
    // Slot written 100 samples before the current write position
    rd_addr    = wptr - HIST_AW'(PREFAULT_SAMPLES); // see RQ5, RQ9
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr <= WPTR_RESET;
    end else begin
      wptr <= next_wptr;
    end
  end

  history_ram u_hist (
    .clk     (clk),
    .wr_en   (sample_valid),
    .wr_addr (wptr),
    .wr_data (scaled),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // ------------------------------------------------------------
  // Capture and report control
  // ------------------------------------------------------------
  state_t           state;
  state_t           next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  triple_t          pre_val;
  triple_t          next_pre_val;
  triple_t          f_a;
  triple_t          next_f_a;
  triple_t          f_val;
  triple_t          next_f_val;
  logic             have;
  logic             next_have;
  logic             ev_valid;
  logic             next_ev_valid;
  trip_event_t      ev;
  trip_event_t      next_ev;

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_pre_val  = pre_val;
    next_f_a      = f_a;
    next_f_val    = f_val;
    next_have     = have;
    next_ev_valid = 1'b0;
    next_ev       = ev;
    case (state)
      ST_IDLE, ST_COLLECT, ST_ARMED: begin
        if (start_edge) begin
          // History read holds the sample 100 ms back
          next_pre_val = rd_data; // see RQ1, RQ2, RQ5
          next_cnt     = CNT_RESET;
          next_state   = ST_COLLECT;
        end else if (state == ST_COLLECT && sample_valid) begin
          next_cnt = cnt + 8'h01;
          if (cnt + 8'h01 == CNT_W'(FAULT_A_SAMPLES)) begin
            next_f_a = scaled; // see RQ6
          end
          if (cnt + 8'h01 == CNT_W'(FAULT_B_SAMPLES)) begin
            next_f_val.ch0 = mean2(f_a.ch0, scaled.ch0); // see RQ6
            next_f_val.ch1 = mean2(f_a.ch1, scaled.ch1); // see RQ6
            next_f_val.ch2 = mean2(f_a.ch2, scaled.ch2); // see RQ6
            next_have      = 1'b1;
            next_state     = ST_ARMED; // see RQ1
          end
        end else if (state == ST_ARMED && trip_edge && have) begin
          next_state = ST_SEND_PF; // see RQ3
        end
      end
      ST_SEND_PF: begin
        next_ev_valid = 1'b1; // see RQ3, RQ4
        next_ev.kind  = EV_PREFAULT; // see RQ11
        next_ev.value = pre_val;
        next_state    = ST_SEND_F;
      end
      ST_SEND_F: begin
        next_ev_valid = 1'b1; // see RQ3, RQ4
        next_ev.kind  = EV_FAULT; // see RQ11
        next_ev.value = f_val;
        next_have     = 1'b0;
        next_state    = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state    <= ST_IDLE;
      cnt      <= CNT_RESET;
      pre_val  <= '0;
      f_a      <= '0;
      f_val    <= '0;
      have     <= 1'b0;
      ev_valid <= 1'b0;
      ev       <= '{kind: EV_PREFAULT, value: '0};
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      pre_val  <= next_pre_val;
      f_a      <= next_f_a;
      f_val    <= next_f_val;
      have     <= next_have;
      ev_valid <= next_ev_valid;
      ev       <= next_ev;
    end
  end

  // ------------------------------------------------------------
  // Outputs: events only, copied to both sinks
  // ------------------------------------------------------------
  logic        next_list_valid;
  logic        next_scada_valid;

  always_comb begin
    next_list_valid  = ev_valid; // see RQ4, RQ8
    next_scada_valid = ev_valid; // see RQ4
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      list_valid  <= 1'b0;
      scada_valid <= 1'b0;
      list_event  <= '{kind: EV_PREFAULT, value: '0};
      scada_event <= '{kind: EV_PREFAULT, value: '0};
    end else begin
      list_valid  <= next_list_valid;
      scada_valid <= next_scada_valid;
      list_event  <= ev;
      scada_event <= ev;
    end
  end

endmodule

// *** src/trip_value_recorder_pkg.sv ***
// Package with constants and types for the trip value recorder
package trip_value_recorder_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int SAMPLE_W    = 16;
  localparam int SCALE_W     = 16;
  localparam int PRIMARY_W   = 32;
  localparam int CHANNELS    = 3;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int SAMPLE_PERIOD_MS = 1;
  localparam int PREFAULT_MS      = 100;
  localparam int FAULT_A_MS       = 10;
  localparam int FAULT_B_MS       = 20;
  localparam int HIST_DEPTH       = 128;
  localparam int HIST_AW          = 7;
  localparam int PREFAULT_SAMPLES = PREFAULT_MS / SAMPLE_PERIOD_MS;
  localparam int FAULT_A_SAMPLES  = FAULT_A_MS / SAMPLE_PERIOD_MS;
  localparam int FAULT_B_SAMPLES  = FAULT_B_MS / SAMPLE_PERIOD_MS;
  localparam int CNT_W            = 8;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [HIST_AW-1:0]   WPTR_RESET = 7'h00;
  localparam logic [CNT_W-1:0]     CNT_RESET  = 8'h00;
  localparam logic [PRIMARY_W-1:0] VAL_RESET  = 32'h00000000;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef logic signed [PRIMARY_W-1:0] primary_t;

  typedef struct packed {
    primary_t ch2;
    primary_t ch1;
    primary_t ch0;
  } triple_t;

  typedef enum logic [1:0] {
    EV_PREFAULT = 2'h1,
    EV_FAULT    = 2'h2
  } event_kind_t;

  typedef struct packed {
    event_kind_t kind;
    triple_t     value;
  } trip_event_t;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_COLLECT = 5'h02,
    ST_ARMED   = 5'h04,
    ST_SEND_PF = 5'h08,
    ST_SEND_F  = 5'h10
  } state_t;

  // Secondary to primary scaling
  function automatic primary_t to_primary(input logic signed [SAMPLE_W-1:0] s,
                                          input logic [SCALE_W-1:0] ratio);
    primary_t se;
    primary_t re;
    // Both factors widened first, product kept to the primary width
    se = primary_t'(s);
    re = primary_t'({1'b0, ratio});
    return se * re;
  endfunction

  // Mean of two primary values
  function automatic primary_t mean2(input primary_t a, input primary_t b);
    logic signed [PRIMARY_W:0] s;
    s = {a[PRIMARY_W-1], a} + {b[PRIMARY_W-1], b};
    return s[PRIMARY_W:1];
  endfunction

endpackage

// *** test/meas_source.sv ***
// Measurement source feeding the recorder
`timescale 1ns/1ps
module meas_source
  import trip_value_recorder_pkg::*;
(
  // Clock
  input  wire logic           clk,
  // Sample stream
  output logic                sample_valid,
  output logic [SAMPLE_W-1:0] sec_ch0,
  output logic [SAMPLE_W-1:0] sec_ch1,
  output logic [SAMPLE_W-1:0] sec_ch2,
  output int                  n_samples
);
  // One source kind on all three channels
  initial begin
    n_samples    = 0;
    sample_valid = 1'b0;
    {sec_ch2, sec_ch1, sec_ch0} = '1;
    forever begin
      repeat (8) @(posedge clk);
      #1;
      sample_valid = 1'b1;
      sec_ch0      = SAMPLE_W'(n_samples * 37 - 3000);
      sec_ch1      = SAMPLE_W'(n_samples * 37 - 2989);
      sec_ch2      = SAMPLE_W'(n_samples * 37 - 2978);
      n_samples++;
      @(posedge clk);
      #1;
      sample_valid = 1'b0;
      {sec_ch2, sec_ch1, sec_ch0} = ~{sec_ch2, sec_ch1, sec_ch0};
    end
  end
endmodule

// *** test/trip_value_recorder_properties.sv ***
// Checker for the trip value recorder outputs
`timescale 1ns/1ps
module trip_value_recorder_properties
  import trip_value_recorder_pkg::*;
(
  // Clock, reset and inputs
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        sample_valid,
  input wire logic        start_request_input,
  input wire logic        trip_trigger_input,
  // Outputs
  input wire logic        list_valid,
  input wire trip_event_t list_event,
  input wire logic        scada_valid,
  input wire trip_event_t scada_event
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [4:0] cnt, next_cnt;
  logic       st_d, next_st_d;
  // ----
  // Samples since start
  // ----
  always_comb begin
    next_st_d = start_request_input;
    next_cnt  = cnt;
    if (start_request_input && !st_d)
      next_cnt = 5'h00;
    else if (sample_valid && cnt != 5'h1f)
      next_cnt = cnt + 5'h01;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt  <= 5'h00;
      st_d <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      st_d <= next_st_d;
    end
  end
  // ----
  // Assertions
  // ----
  a_twin_valid: assert property (list_valid == scada_valid)
    else $error("valid outputs differ");
  a_twin_data: assert property (list_valid |-> list_event == scada_event)
    else $error("event outputs differ");
  a_pf_then_f: assert property (list_valid && list_event.kind == EV_PREFAULT |=>
    list_valid && list_event.kind == EV_FAULT) else $error("fault event missing");
  a_f_after_pf: assert property (list_valid && list_event.kind == EV_FAULT |->
    $past(list_valid) && $past(list_event.kind) == EV_PREFAULT) else $error("stray fault event");
  a_valid_pulse: assert property (list_valid && list_event.kind == EV_FAULT |=> !list_valid)
    else $error("valid too long");
  a_trip_cause: assert property ($rose(list_valid) |-> $past(trip_trigger_input, 4))
    else $error("event without trip");
  a_data_hold: assert property (!list_valid |-> $stable(list_event))
    else $error("event data moved");
  a_capture_done: assert property ($rose(list_valid) |-> cnt >= 5'h14)
    else $error("event before capture end");
  c_start: cover property ($rose(start_request_input));
  c_prefault: cover property (list_valid && list_event.kind == EV_PREFAULT);
  c_fault: cover property (list_valid && list_event.kind == EV_FAULT);
endmodule
bind trip_value_recorder trip_value_recorder_properties chk (.clk, .rstn, .sample_valid, .start_request_input,
  .trip_trigger_input, .list_valid, .list_event, .scada_valid, .scada_event);

// *** test/trip_value_recorder_tb_top.sv ***
// Testbench for the trip value recorder
`timescale 1ns/1ps
module trip_value_recorder_tb_top;
  import trip_value_recorder_pkg::*;
  logic                clk, rstn, sv, st, tr, lv, scv;
  logic [SAMPLE_W-1:0] s0, s1, s2;
  trip_event_t         le, se;
  int                  n_samples, k, fail_count, num_checks;
  meas_source src (.clk, .sample_valid(sv), .sec_ch0(s0), .sec_ch1(s1), .sec_ch2(s2), .n_samples);
  trip_value_recorder dut (.clk, .rstn, .sample_valid(sv), .sec_ch0(s0), .sec_ch1(s1), .sec_ch2(s2),
    .ratio_ch0(16'h0002), .ratio_ch1(16'h0003), .ratio_ch2(16'h0004), .start_request_input(st),
    .trip_trigger_input(tr), .list_valid(lv), .list_event(le), .scada_valid(scv), .scada_event(se));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----
  // Helpers
  // ----
  function automatic primary_t pv(int i, int c);
    return primary_t'((i * 37 - 3000 + 11 * c) * (c + 2));
  endfunction
  function automatic trip_event_t ev(logic flt);
    trip_event_t e;
    e.kind = flt ? EV_FAULT : EV_PREFAULT;
    for (int c = 0; c < CHANNELS; c++)
      e.value[c*PRIMARY_W +: PRIMARY_W] = flt ? (pv(k + 9, c) + pv(k + 19, c)) >>> 1 : pv(k - 100, c);
    return e;
  endfunction
  task automatic cmp(string what, logic [33:0] exp, logic [33:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic start_cap;
    st = 1'b0;
    repeat (2) @(n_samples);
    tick(2);
    st = 1'b1;
    k  = n_samples;
  endtask
  task automatic trip_at(int m);
    wait (n_samples >= m);
    tick(1);
    tr = 1'b1;
  endtask
  task automatic expect_events;
    int t;
    t = 0;
    while (lv !== 1'b1 && t < 100) begin
      tick(1);
      t++;
    end
    cmp("list prefault", ev(1'b0), le);
    cmp("scada prefault", ev(1'b0), se);
    cmp("valid pair", 34'h3, {32'h0, lv, scv});
    tick(1);
    cmp("list fault", ev(1'b1), le);
    cmp("scada fault", ev(1'b1), se);
    tick(1);
    cmp("valid off", 34'h0, {32'h0, lv, scv});
    tr = 1'b0;
    st = 1'b0;
  endtask
  task automatic quiet(string what);
    logic seen;
    seen = 1'b0;
    repeat (30) begin
      tick(1);
      seen |= lv | scv;
    end
    cmp(what, 34'h0, {33'h0, seen});
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_basic;
    wait (n_samples >= 130);
    start_cap();
    trip_at(k + 22);
    expect_events();
  endtask
  task automatic t_restart;
    start_cap();
    wait (n_samples >= k + 25);
    start_cap();
    trip_at(k + 22);
    expect_events();
  endtask
  task automatic t_refused;
    start_cap();
    trip_at(k + 5);
    quiet("trip in collection");
    tr = 1'b0;
    trip_at(k + 22);
    expect_events();
    tick(4);
    tr = 1'b1;
    quiet("trip after report");
    tr = 1'b0;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    rstn       = 1'b0;
    st         = 1'b0;
    tr         = 1'b0;
    fail_count = 0;
    num_checks = 0;
    tick(3);
    rstn = 1'b1;
    t_basic();
    t_restart();
    t_refused();
    results();
  end
  initial begin
    #100us;
    fail_count++;
    results();
  end
endmodule
